/* File: verilog/mdc_pkg.sv */
/*
 * Shared constants of the motor drive configuration block: register
 * offsets, reset values, field positions, codes and timing figures.
 * Assumes a single 100 MHz clock domain.
 */
`default_nettype none
package mdc_pkg;
    // register map, byte offsets of the serial management space
    localparam logic [7:0]  PERI_CFG1_OFS   = 8'haa;
    localparam logic [7:0]  GD_CFG1_OFS     = 8'hac;
    localparam logic [31:0] PERI_CFG1_RST   = 32'h40000000;
    localparam logic [31:0] GD_CFG1_RST     = 32'h10228100;

    // peripheral_config_one fields
    localparam int DIR_SRC_LSB      = 19;
    localparam int DIR_SRC_W        = 2;
    localparam int DIR_MODE_BIT     = 18;
    localparam int SELFTEST_BIT     = 17;
    localparam int BRK_DELTA_LSB    = 13;
    localparam int BRK_DELTA_W      = 4;
    localparam int BRK_MOD_LSB      = 10;
    localparam int BRK_MOD_W        = 3;
    localparam int SPD_RANGE_BIT    = 9;

    // gate_driver_config_one fields
    localparam int SLEW_LSB         = 26;
    localparam int SLEW_W           = 2;
    localparam int FLT_CLR_BIT      = 23;
    localparam int OV_LEVEL_BIT     = 19;
    localparam int OV_ON_BIT        = 18;
    localparam int TW_REPORT_BIT    = 16;

    // rotation-sense source codes
    localparam logic [1:0] DIR_SRC_PIN0 = 2'h0;
    localparam logic [1:0] DIR_SRC_CW   = 2'h1;
    localparam logic [1:0] DIR_SRC_CCW  = 2'h2;

    // brake threshold encodings, percent
    localparam logic [3:0] DELTA_FINE_MAX  = 4'ha;
    localparam logic [6:0] DELTA_FINE_STEP = 7'h05;
    localparam logic [6:0] DELTA_FINE_TOP  = 7'h32;
    localparam logic [6:0] DELTA_WIDE_STEP = 7'h0a;
    localparam logic [6:0] MOD_BASE_PCT    = 7'h1e;
    localparam logic [6:0] MOD_STEP_PCT    = 7'h0a;
    localparam logic [6:0] PCT_FULL        = 7'h64;

    // digital speed input ranges, Hz
    localparam logic [16:0] SPD_LO_MIN_HZ = 17'h0000a;
    localparam logic [16:0] SPD_SPLIT_HZ  = 17'h00145;
    localparam logic [16:0] SPD_HI_MAX_HZ = 17'h186a0;

    // timing
    localparam int CLK_MHZ          = 100;
    localparam int STARTUP_TIME_US  = 10;
    localparam int STARTUP_CYC      = STARTUP_TIME_US * CLK_MHZ;
endpackage : mdc_pkg
`default_nettype wire

/* File: verilog/mdc_sync.sv */
/*
 * Two-flop level synchroniser, parameterised width.
 * Assumes inputs are slow levels from pins; no pulse capture.
 */
`timescale 1ns/100ps
`default_nettype none
module mdc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule : mdc_sync
`default_nettype wire

/* File: verilog/mdc_brake_limits.sv */
/*
 * Decodes the two active-brake entry codes into percent figures.
 * Purely combinational; the caller registers the results.
 */
`timescale 1ns/100ps
`default_nettype none
module mdc_brake_limits
    import mdc_pkg::*;
(
    input  wire logic [BRK_DELTA_W-1:0] delta_code,
    input  wire logic [BRK_MOD_W-1:0]   mod_code,
    output logic                        delta_valid,
    output logic [6:0]                  delta_pct,
    output logic [6:0]                  mod_pct
);
    logic [6:0] dcode7;
    logic [6:0] mcode7;

    assign dcode7 = {3'h0, delta_code};
    assign mcode7 = {4'h0, mod_code};

    always_comb begin
        // code 0 is reserved: no speed-delta entry
        delta_valid = (delta_code != '0); // RQ4
        if (delta_code <= DELTA_FINE_MAX) begin
            delta_pct = 7'(dcode7 * DELTA_FINE_STEP); // RQ4
        end else begin
            delta_pct = 7'(DELTA_FINE_TOP + (dcode7 - {3'h0, DELTA_FINE_MAX}) * DELTA_WIDE_STEP); // RQ4
        end
        if (mod_code == '0) begin
            mod_pct = 7'h00; // RQ5
        end else begin
            mod_pct = 7'(MOD_BASE_PCT + mcode7 * MOD_STEP_PCT); // RQ5
        end
    end
endmodule : mdc_brake_limits
`default_nettype wire

/* File: verilog/mdc_config_regs.sv */
/*
 * Motor drive configuration registers and the control they steer:
 * rotation sense, reversal handling, power-up self test, active brake
 * entry, digital speed range, slew code, fault clear, overvoltage and
 * thermal warning reporting.
 * Assumes a register access port from the serial management engine on
 * the same clock; pins dir, comparators and warning are asynchronous.
 */
//
// Function
// RQ1: direction source: codes 0 and 3 follow pin, 1 forces clockwise, 2 counter-clockwise.
// RQ2: reversal bit 0 stops and re-detects speed; 1 reverses through reverse drive.
// RQ3: power-up check bit set runs self test at power up, clear skips it.
// RQ4: brake when speed gap below threshold; code 0 reserved, 5% then 10% steps.
// RQ5: brake when modulation index exceeds limit; 0%, then 40% to 100% in steps.
// RQ6: speed-range bit selects 325 Hz-100 kHz or 10 Hz-325 Hz input.
// RQ7: gate-driver word at offset ac loads 10228100 at reset.
// RQ8: two-bit slew code selects 25/50/125/200 V/us, passed to output stage.
// RQ9: writing 1 to fault clear clears latched faults; bit self-clears.
// RQ10: overvoltage level bit selects 32 V trip when 0, 20 V when 1.
// RQ11: overvoltage protection acts only while its enable bit is 1.
// RQ12: thermal warning drives fault pin only while report bit is 1.
// RQ13: peripheral word at offset aa loads 40000000 at reset.
// RQ14: reserved bits are plain read/write storage with no effect.
`timescale 1ns/100ps
`default_nettype none
module mdc_config_regs
    import mdc_pkg::*;
#(
    parameter int SPEED_W = 16
) (
    input  wire logic               ref_clk,
    input  wire logic               arst_n,
    // register access port
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    input  wire logic [7:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    output logic [31:0]             reg_rdata,
    output logic                    reg_rd_valid,
    // pins
    input  wire logic               dir_pin,
    input  wire logic               vm_over_32v,
    input  wire logic               vm_over_20v,
    input  wire logic               thermal_warn,
    // speed loop, same clock
    input  wire logic               decel_req,
    input  wire logic [SPEED_W-1:0] target_speed,
    input  wire logic [SPEED_W-1:0] present_speed,
    input  wire logic [6:0]         mod_index_pct,
    input  wire logic [16:0]        speed_freq_hz,
    // control outputs
    output logic                    dir_ccw,
    output logic                    reverse_drive_req,
    output logic                    stop_isd_req,
    output logic                    selftest_start,
    output logic                    active_brake,
    output logic                    speed_range_low,
    output logic                    speed_freq_ok,
    output logic [SLEW_W-1:0]       slew_code,
    output logic                    fault_clear_pulse,
    output logic                    ovp_level_20v,
    output logic                    ovp_fault_latched,
    output logic                    fault_alert_pin_n
);
    typedef enum logic [2:0] {
        MDC_ST_HOLD  = 3'b001,
        MDC_ST_CHECK = 3'b010,
        MDC_ST_RUN   = 3'b100
    } mdc_start_t;

    logic                    rst_meta_reg;
    logic                    rst_sync_reg;
    logic                    rst_n;
    logic [31:0]             peri_reg;
    logic [31:0]             gd_reg;
    logic [3:0]              pin_sync;
    logic                    dir_sync;
    logic                    ov32_sync;
    logic                    ov20_sync;
    logic                    tw_sync;
    mdc_start_t              start_reg;
    mdc_start_t              start_next;
    logic [15:0]             start_cnt_reg;
    logic                    dir_next;
    logic                    dir_valid_reg;
    logic                    delta_valid;
    logic [6:0]              delta_pct;
    logic [6:0]              mod_pct;
    logic [SPEED_W-1:0]      speed_gap;
    logic                    gap_below;
    logic                    mod_above;
    logic                    ov_trip;
    logic                    clr_now;

    localparam logic [15:0] START_CYC_L = 16'(STARTUP_CYC);

    // scaled comparison: a*100 against pct*b, no division needed
    function automatic logic pct_below(input logic [SPEED_W-1:0] a,
                                       input logic [SPEED_W-1:0] b,
                                       input logic [6:0]         pct);
        logic [SPEED_W+6:0] lhs;
        logic [SPEED_W+6:0] rhs;
        lhs = (SPEED_W+7)'(a) * (SPEED_W+7)'(PCT_FULL);
        rhs = (SPEED_W+7)'(b) * (SPEED_W+7)'(pct);
        return lhs < rhs;
    endfunction : pct_below

    // reset released through two flops
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rst_n = rst_sync_reg;

    mdc_sync #(
        .W (4)
    ) u_pin_sync (
        .clk   (ref_clk),
        .rst_n (rst_n),
        .d     ({thermal_warn, vm_over_20v, vm_over_32v, dir_pin}),
        .q     (pin_sync)
    );
    assign dir_sync  = pin_sync[0];
    assign ov32_sync = pin_sync[1];
    assign ov20_sync = pin_sync[2];
    assign tw_sync   = pin_sync[3];

    // register writes; fault clear never stores a one
    assign clr_now = reg_wr && (reg_addr == GD_CFG1_OFS) && reg_wdata[FLT_CLR_BIT]; // RQ9

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            peri_reg <= PERI_CFG1_RST; // RQ13
        end else if (reg_wr && reg_addr == PERI_CFG1_OFS) begin
            peri_reg <= reg_wdata; // RQ14
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gd_reg <= GD_CFG1_RST; // RQ7
        end else if (reg_wr && reg_addr == GD_CFG1_OFS) begin
            gd_reg              <= reg_wdata; // RQ14
            gd_reg[FLT_CLR_BIT] <= 1'b0; // RQ9
        end
    end

    // reads answer one cycle later; unmapped offsets read zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata    <= 32'h00000000;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    PERI_CFG1_OFS: reg_rdata <= peri_reg;
                    GD_CFG1_OFS:   reg_rdata <= gd_reg;
                    default:       reg_rdata <= 32'h00000000;
                endcase
            end
        end
    end

    // power-up sequencing: the hold lets the configuration settle
    always_comb begin
        start_next = start_reg;
        case (start_reg)
            MDC_ST_HOLD: begin
                if (start_cnt_reg == START_CYC_L - 16'h0001) begin
                    start_next = MDC_ST_CHECK;
                end
            end
            MDC_ST_CHECK: start_next = MDC_ST_RUN;
            MDC_ST_RUN:   start_next = MDC_ST_RUN;
            default:      start_next = MDC_ST_HOLD;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_reg     <= MDC_ST_HOLD;
            start_cnt_reg <= 16'h0000;
        end else begin
            start_reg <= start_next;
            if (start_reg == MDC_ST_HOLD) begin
                start_cnt_reg <= start_cnt_reg + 16'h0001;
            end
        end
    end

    // self test only once, at the power-up check point
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            selftest_start <= 1'b0;
        end else begin
            selftest_start <= (start_reg == MDC_ST_CHECK) && peri_reg[SELFTEST_BIT]; // RQ3
        end
    end

    // direction resolution
    always_comb begin
        case (peri_reg[DIR_SRC_LSB +: DIR_SRC_W])
            DIR_SRC_CW:  dir_next = 1'b0; // RQ1
            DIR_SRC_CCW: dir_next = 1'b1; // RQ1
            default:     dir_next = dir_sync; // RQ1
        endcase
    end

    // a change is only acted on once running, so power-up is not a reversal
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_ccw           <= 1'b0;
            dir_valid_reg     <= 1'b0;
            reverse_drive_req <= 1'b0;
            stop_isd_req      <= 1'b0;
        end else begin
            dir_ccw           <= dir_next;
            dir_valid_reg     <= (start_reg == MDC_ST_RUN);
            reverse_drive_req <= dir_valid_reg && (dir_next != dir_ccw) && peri_reg[DIR_MODE_BIT]; // RQ2
            stop_isd_req      <= dir_valid_reg && (dir_next != dir_ccw) && !peri_reg[DIR_MODE_BIT]; // RQ2
        end
    end

    mdc_brake_limits u_brake_limits (
        .delta_code  (peri_reg[BRK_DELTA_LSB +: BRK_DELTA_W]),
        .mod_code    (peri_reg[BRK_MOD_LSB +: BRK_MOD_W]),
        .delta_valid (delta_valid),
        .delta_pct   (delta_pct),
        .mod_pct     (mod_pct)
    );

    assign speed_gap = (target_speed > present_speed) ? (target_speed - present_speed)
                                                      : (present_speed - target_speed);
    assign gap_below = delta_valid && pct_below(speed_gap, target_speed, delta_pct); // RQ4
    assign mod_above = mod_index_pct > mod_pct; // RQ5

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            active_brake <= 1'b0;
        end else begin
            active_brake <= decel_req && (gap_below || mod_above); // RQ4 RQ5
        end
    end

    // digital speed input window
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            speed_range_low <= 1'b0;
            speed_freq_ok   <= 1'b0;
        end else begin
            speed_range_low <= peri_reg[SPD_RANGE_BIT]; // RQ6
            if (peri_reg[SPD_RANGE_BIT]) begin
                speed_freq_ok <= (speed_freq_hz >= SPD_LO_MIN_HZ) && (speed_freq_hz <= SPD_SPLIT_HZ); // RQ6
            end else begin
                speed_freq_ok <= (speed_freq_hz >= SPD_SPLIT_HZ) && (speed_freq_hz <= SPD_HI_MAX_HZ); // RQ6
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            slew_code         <= GD_CFG1_RST[SLEW_LSB +: SLEW_W];
            fault_clear_pulse <= 1'b0;
            ovp_level_20v     <= 1'b0;
        end else begin
            slew_code         <= gd_reg[SLEW_LSB +: SLEW_W]; // RQ8
            fault_clear_pulse <= clr_now; // RQ9
            ovp_level_20v     <= gd_reg[OV_LEVEL_BIT]; // RQ10
        end
    end

    // overvoltage latch; a trip in the clearing cycle still latches
    assign ov_trip = gd_reg[OV_ON_BIT] && (gd_reg[OV_LEVEL_BIT] ? ov20_sync : ov32_sync); // RQ10 RQ11

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ovp_fault_latched <= 1'b0;
        end else if (ov_trip) begin
            ovp_fault_latched <= 1'b1; // RQ11
        end else if (clr_now) begin
            ovp_fault_latched <= 1'b0; // RQ9
        end
    end

    // pin is low for a latched fault or a reported warning
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_alert_pin_n <= 1'b1;
        end else begin
            fault_alert_pin_n <= !((ovp_fault_latched || ov_trip) ||
                                   (tw_sync && gd_reg[TW_REPORT_BIT])); // RQ12
        end
    end
endmodule : mdc_config_regs
`default_nettype wire

/* File: bench/mdc_config_regs_chk.sv */
/*
 * Port-level checker for the motor drive configuration registers.
 * Assumes the single ref_clk domain; bound onto every mdc_config_regs instance.
 */
`timescale 1ns/100ps
`default_nettype none
module mdc_config_regs_chk
    import mdc_pkg::*;
#(
    parameter int SPEED_W = 16
) (
    input  wire logic              ref_clk,
    input  wire logic              arst_n,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic [31:0]       reg_rdata,
    input  wire logic              reg_rd_valid,
    input  wire logic              decel_req,
    input  wire logic              dir_ccw,
    input  wire logic              reverse_drive_req,
    input  wire logic              selftest_start,
    input  wire logic              active_brake,
    input  wire logic              speed_range_low,
    input  wire logic [SLEW_W-1:0] slew_code,
    input  wire logic              fault_clear_pulse,
    input  wire logic              ovp_level_20v,
    input  wire logic              ovp_fault_latched,
    input  wire logic              fault_alert_pin_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence s_gd_wr;
        reg_wr && reg_addr == GD_CFG1_OFS;
    endsequence
    sequence s_peri_wr;
        reg_wr && reg_addr == PERI_CFG1_OFS;
    endsequence
    sequence s_read;
        reg_rd ##1 reg_rd_valid;
    endsequence

    // word lands on the taking edge, its copies reach the outputs one edge later
    a_slew_copy: assert property (s_gd_wr |=> ##1 slew_code == $past(reg_wdata[27:26], 2))
        else $error("slew code not taken from write");
    a_level_copy: assert property (s_gd_wr |=> ##1 ovp_level_20v == $past(reg_wdata[OV_LEVEL_BIT], 2))
        else $error("overvoltage level not taken from write");
    a_clear_cause: assert property (fault_clear_pulse |-> $past(reg_wr && reg_addr == GD_CFG1_OFS && reg_wdata[23]))
        else $error("fault clear pulse without a clear write");
    a_range_copy: assert property (s_peri_wr |=> ##1 speed_range_low == $past(reg_wdata[SPD_RANGE_BIT], 2))
        else $error("speed range not taken from write");
    a_read_answer: assert property (reg_rd |-> s_read)
        else $error("read not answered next cycle");
    a_unmapped_zero: assert property (reg_rd && reg_addr != PERI_CFG1_OFS && reg_addr != GD_CFG1_OFS |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_dir_forced: assert property (s_peri_wr ##0 reg_wdata[20:19] == 2'h1 |=> ##1 !dir_ccw)
        else $error("forced clockwise not applied");
    a_dir_forced_ccw: assert property (s_peri_wr ##0 reg_wdata[20:19] == 2'h2 |=> ##1 dir_ccw)
        else $error("forced counter-clockwise not applied");
    a_rev_change: assert property (reverse_drive_req |-> dir_ccw != $past(dir_ccw) ##1 !reverse_drive_req)
        else $error("reverse drive request without direction change");
    a_selftest_once: assert property (selftest_start |=> (!selftest_start) [*8])
        else $error("self test start repeated");
    a_brake_idle: assert property (!decel_req |=> !active_brake)
        else $error("brake without deceleration");
    a_ovp_alert: assert property (ovp_fault_latched && $past(ovp_fault_latched) |-> !fault_alert_pin_n)
        else $error("latched overvoltage not on alert pin");
endmodule : mdc_config_regs_chk

bind mdc_config_regs mdc_config_regs_chk #(.SPEED_W(SPEED_W)) chk_u (.ref_clk, .arst_n, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid, .decel_req, .dir_ccw, .reverse_drive_req,
    .selftest_start, .active_brake, .speed_range_low, .slew_code, .fault_clear_pulse, .ovp_level_20v,
    .ovp_fault_latched, .fault_alert_pin_n);
`default_nettype wire

/* File: bench/mdc_config_regs_tb.sv */
/*
 * Self-checking bench for mdc_config_regs: register reads queued and
 * checked by a monitor, control outputs compared after each step.
 * Assumes the package timing; one 100 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none
module mdc_config_regs_tb
    import mdc_pkg::*;
();
    logic        ref_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, dir_pin = 1'b1;
    logic        vm_over_32v = 1'b0, vm_over_20v = 1'b0, thermal_warn = 1'b0, decel_req = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, lfsr = 32'h314be751, d;
    logic [15:0] target_speed = 16'h03e8, present_speed = 16'h0000;
    logic [6:0]  mod_index_pct = 7'h00;
    logic [16:0] speed_freq_hz = 17'h00000;
    logic        reg_rd_valid, dir_ccw, reverse_drive_req, stop_isd_req, selftest_start, active_brake;
    logic        speed_range_low, speed_freq_ok, fault_clear_pulse, ovp_level_20v, ovp_fault_latched;
    logic        fault_alert_pin_n;
    logic [1:0]  slew_code;
    logic [31:0] expq[$];
    int          errors = 0, compares = 0, cycles = 0, n_st = 0, n_rev = 0, n_stop = 0, n_fc = 0;
    // {delta, mod, decel, present, mod index, expected brake}
    logic [31:0] bk[10] = '{32'haf025865, 32'haf019064, 32'hbf019064, 32'hcf019065, 32'h0f03e864,
                            32'h01019003, 32'h03019050, 32'h03019053, 32'h1e03e8fe, 32'hff000165};
    // {range, expected ok, frequency}
    logic [31:0] sp[8] = '{32'h00100145, 32'h001186a0, 32'h000186a1, 32'h00000144,
                           32'h8010000a, 32'h80000009, 32'h80100145, 32'h80000146};

    mdc_config_regs #(.SPEED_W(16)) dut_u (.ref_clk, .arst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_rd_valid, .dir_pin, .vm_over_32v, .vm_over_20v, .thermal_warn, .decel_req,
        .target_speed, .present_speed, .mod_index_pct, .speed_freq_hz, .dir_ccw, .reverse_drive_req,
        .stop_isd_req, .selftest_start, .active_brake, .speed_range_low, .speed_freq_ok, .slew_code,
        .fault_clear_pulse, .ovp_level_20v, .ovp_fault_latched, .fault_alert_pin_n);

    always #5 ref_clk = ~ref_clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic final_report;
        if (errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report

    // returns one edge after the taking edge: output copies of a word need two edges
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : idle

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    always @(negedge ref_clk) begin
        if (reg_rd_valid === 1'b1) begin
            if (expq.size() > 0) chk(reg_rdata, expq.pop_front());
            else chk(32'h0, 32'h1);
        end
    end

    // pulses are counted so single-cycle outputs are never missed
    always @(posedge ref_clk) begin
        cycles++;
        n_st += int'(selftest_start === 1'b1);
        n_rev += int'(reverse_drive_req === 1'b1);
        n_stop += int'(stop_isd_req === 1'b1);
        n_fc += int'(fault_clear_pulse === 1'b1);
        if (cycles > 20000) begin
            errors++;
            final_report();
        end
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        idle(3);
        rd(PERI_CFG1_OFS, PERI_CFG1_RST);
        rd(GD_CFG1_OFS, GD_CFG1_RST);
        wr(PERI_CFG1_OFS, PERI_CFG1_RST | 32'h00020000);
        idle(STARTUP_CYC + 10);
        chk(n_st, 1);
        // second reset leaves the self test bit clear, so no new start
        @(posedge ref_clk);
        arst_n <= 1'b0;
        idle(2);
        @(posedge ref_clk);
        arst_n <= 1'b1;
        idle(STARTUP_CYC + 10);
        chk(n_st, 1);
        chk(32'(dir_ccw), 32'h1);
        for (int i = 0; i < 4; i++) begin
            wr(PERI_CFG1_OFS, PERI_CFG1_RST | 32'h00040000 | (32'((i + 1) % 4) << 19));
            chk(32'(dir_ccw), 32'(i != 0));
        end
        chk(n_rev, 2);
        chk(n_stop, 0);
        wr(PERI_CFG1_OFS, PERI_CFG1_RST);
        @(posedge ref_clk);
        dir_pin <= 1'b0;
        idle(5);
        chk(32'(dir_ccw), 32'h0);
        chk(n_stop, 1);
        foreach (bk[i]) begin
            wr(PERI_CFG1_OFS, PERI_CFG1_RST | (32'(bk[i][31:25]) << 10));
            @(posedge ref_clk);
            decel_req <= bk[i][24];
            present_speed <= bk[i][23:8];
            mod_index_pct <= bk[i][7:1];
            idle(2);
            chk(32'(active_brake), 32'(bk[i][0]));
        end
        foreach (sp[i]) begin
            wr(PERI_CFG1_OFS, PERI_CFG1_RST | (32'(sp[i][31]) << 9));
            @(posedge ref_clk);
            speed_freq_hz <= sp[i][16:0];
            idle(2);
            chk(32'(speed_range_low), 32'(sp[i][31]));
            chk(32'(speed_freq_ok), 32'(sp[i][20]));
        end
        for (int i = 0; i < 4; i++) begin
            wr(GD_CFG1_OFS, GD_CFG1_RST | (32'(i) << 26) | (32'(i % 2) << 19));
            chk(32'(slew_code), 32'(i));
            chk(32'(ovp_level_20v), 32'(i % 2));
        end
        wr(GD_CFG1_OFS, GD_CFG1_RST);
        @(posedge ref_clk);
        vm_over_32v <= 1'b1;
        vm_over_20v <= 1'b1;
        idle(5);
        chk(32'(ovp_fault_latched), 32'h0);
        chk(32'(fault_alert_pin_n), 32'h1);
        @(posedge ref_clk);
        vm_over_32v <= 1'b0;
        wr(GD_CFG1_OFS, GD_CFG1_RST | 32'h00040000);
        idle(4);
        chk(32'(ovp_fault_latched), 32'h0);
        @(posedge ref_clk);
        vm_over_32v <= 1'b1;
        idle(4);
        chk(32'(ovp_fault_latched), 32'h1);
        chk(32'(fault_alert_pin_n), 32'h0);
        // a trip still seen through the synchroniser would win over the clear
        @(posedge ref_clk);
        vm_over_32v <= 1'b0;
        idle(2);
        wr(GD_CFG1_OFS, GD_CFG1_RST | 32'h00840000);
        idle(2);
        chk(32'(ovp_fault_latched), 32'h0);
        chk(32'(fault_alert_pin_n), 32'h1);
        wr(GD_CFG1_OFS, GD_CFG1_RST | 32'h000c0000);
        idle(4);
        chk(32'(ovp_fault_latched), 32'h1);
        @(posedge ref_clk);
        vm_over_20v <= 1'b0;
        idle(2);
        wr(GD_CFG1_OFS, GD_CFG1_RST | 32'h008c0000);
        idle(2);
        chk(32'(ovp_fault_latched), 32'h0);
        rd(GD_CFG1_OFS, GD_CFG1_RST | 32'h000c0000);
        chk(n_fc, 2);
        @(posedge ref_clk);
        thermal_warn <= 1'b1;
        idle(5);
        chk(32'(fault_alert_pin_n), 32'h1);
        wr(GD_CFG1_OFS, GD_CFG1_RST | 32'h00010000);
        idle(4);
        chk(32'(fault_alert_pin_n), 32'h0);
        @(posedge ref_clk);
        thermal_warn <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            d = lfsr;
            wr(PERI_CFG1_OFS, d);
            rd(PERI_CFG1_OFS, d);
            wr(GD_CFG1_OFS, d);
            rd(GD_CFG1_OFS, d & 32'hff7fffff);
        end
        // unmapped space: write dropped, read gives zero
        wr(8'h10, 32'hffffffff);
        rd(8'h10, 32'h0);
        rd(PERI_CFG1_OFS, d);
        idle(3);
        final_report();
    end
endmodule : mdc_config_regs_tb
`default_nettype wire
